//--- logic/xlc_pkg.sv
// constants, field layouts and decode types for the translation control bank
// assumes one processor clock; software reaches it by system-register access
//
// Contract
// - low-level walk disable bit faults TLB miss
// - low-level region spans two to (64 minus offset)
// - decode low-level name and host alias name
// - deny EL0; redirect EL2 under host extension
// - trap EL1 reads and writes to EL2
// - cross-name EL3 accesses need explicit synchronisation
// - hypervisor register is 64 bits, reserved bits
// - unknown reset; reads zero without EL2
// - layout selects walk controls or base register
// - hierarchical disable zeroes table permission bits
// - walker ignores descriptor bits 62 to 59
// - dirty update needs enable and access update
// - access flag update bit, zero when absent
// - top byte ignored in EL2 address match
// - zero target top byte before PC load, all ones for host upper range
// - physical size decode, reserved acts as 101
// - granule decode, reserved acts as chosen size
// - walk shareability decode
// - walk cacheability decode for both registers
// - hypervisor low region size from offset field
// - host layout upper zero, two hierarchy disables
// - fields may be cached in TLB entries
package xlc_pkg;

    // system instruction encoding
    localparam logic [1:0] SYS_OP0      = 2'h3;
    localparam logic [3:0] SYS_CRN      = 4'h2;
    localparam logic [3:0] SYS_CRM      = 4'h0;
    localparam logic [2:0] SYS_OP2      = 3'h2;
    localparam logic [2:0] OP1_LOW      = 3'h0;
    localparam logic [2:0] OP1_ALIAS    = 3'h5;
    localparam logic [2:0] OP1_HYP      = 3'h4;

    // exception levels
    localparam logic [1:0] EL0          = 2'h0;
    localparam logic [1:0] EL1          = 2'h1;
    localparam logic [1:0] EL2          = 2'h2;
    localparam logic [1:0] EL3          = 2'h3;

    // field positions, shared tail layout
    localparam int TSZ_LO   = 0;
    localparam int TSZ_W    = 6;
    localparam int WALK_DISABLE_LOW_POS = 7;
    localparam int IRGN_LO  = 8;
    localparam int ORGN_LO  = 10;
    localparam int SH_LO    = 12;
    localparam int TG_LO    = 14;
    localparam int PS_LO    = 16;
    localparam int IPS_LO   = 32;
    // hypervisor layout, host extension clear
    localparam int TBI_POS  = 20;
    localparam int HA_LO_POS = 21;
    localparam int HD_LO_POS = 22;
    localparam int HPD_POS  = 24;
    // host layout
    localparam int EPD1_POS = 23;
    localparam int TBI0_POS = 37;
    localparam int TBI1_POS = 38;
    localparam int HA_HI_POS = 39;
    localparam int HD_HI_POS = 40;
    localparam int HIER_PERM_DISABLE_LOW_POS = 41;
    localparam int HIER_PERM_DISABLE_HIGH_POS = 42;
    localparam int VA_SEL_POS = 55;

    // writable masks and reserved-one pattern
    localparam logic [63:0] LOW_WMASK   = 64'h0000_07F7_FFFF_FFBF;
    localparam logic [63:0] HYP0_WMASK  = 64'h0000_0000_0177_FF3F;
    localparam logic [63:0] HYP0_RES1   = 64'h0000_0000_8080_0000;
    localparam logic [63:0] HYP1_WMASK  = 64'h0000_07F7_FFFF_FFBF;
    localparam logic [63:0] REG_RESET   = 64'h0000_0000_0000_0000;

    // descriptor upper attributes, bits 63:59
    localparam int ATTR_W      = 5;
    localparam logic [4:0] ATTR_KEEP_NS = 5'h10;

    // region size base and top byte values
    localparam logic [6:0] REGION_BASE_LOG2 = 7'h40;
    localparam logic [7:0] TOP_ZERO = 8'h00;
    localparam logic [7:0] TOP_ONE  = 8'hFF;

    // address widths for physical size codes
    localparam logic [5:0] PA_32 = 6'h20;
    localparam logic [5:0] PA_36 = 6'h24;
    localparam logic [5:0] PA_40 = 6'h28;
    localparam logic [5:0] PA_42 = 6'h2A;
    localparam logic [5:0] PA_44 = 6'h2C;
    localparam logic [5:0] PA_48 = 6'h30;

    typedef enum logic [1:0] {GRAN_4K, GRAN_16K, GRAN_64K} xlc_gran_e;
    typedef enum logic [1:0] {SH_NONE, SH_OUTER, SH_INNER} xlc_share_e;
    typedef enum logic [1:0] {
        CA_NONCACHE, CA_WB_ALLOC, CA_WT, CA_WB_NOALLOC
    } xlc_cache_e;
    typedef enum logic {RG_LOW_LEVEL, RG_HYP} xlc_regime_e;
    typedef enum logic [1:0] {TGT_NONE, TGT_LOW, TGT_HYP, TGT_ZERO} xlc_tgt_e;

endpackage

//--- logic/xlc_field_decode.sv
// decodes one region's walk attribute fields into walker terms
// assumes raw field codes from a stored control register; purely combinational
`timescale 1ns/1ps
module xlc_field_decode
    import xlc_pkg::*;
(
    // raw codes
    input  wire logic [2:0]   psCode,
    input  wire logic [1:0]   tgCode,
    input  wire logic [1:0]   shCode,
    input  wire logic [1:0]   orgnCode,
    input  wire logic [1:0]   irgnCode,
    input  wire logic [5:0]   tszCode,
    // decoded
    output xlc_gran_e         granule,
    output xlc_share_e        share,
    output xlc_cache_e        outerCache,
    output xlc_cache_e        innerCache,
    output logic      [5:0]   paBits,
    output logic      [6:0]   regionLog2
);

    always_comb begin
        case (psCode)
            3'h0:    paBits = PA_32;
            3'h1:    paBits = PA_36;
            3'h2:    paBits = PA_40;
            3'h3:    paBits = PA_42;
            3'h4:    paBits = PA_44;
            default: paBits = PA_48;
        endcase
        // reserved granule code falls back to 4KB, readback keeps the code
        case (tgCode)
            2'h1:    granule = GRAN_64K;
            2'h2:    granule = GRAN_16K;
            default: granule = GRAN_4K;
        endcase
        // reserved code is unpredictable; non-shareable is the safe pick
        case (shCode)
            2'h2:    share = SH_OUTER;
            2'h3:    share = SH_INNER;
            default: share = SH_NONE;
        endcase
        outerCache = xlc_cache_e'(orgnCode);
        innerCache = xlc_cache_e'(irgnCode);
        regionLog2 = REGION_BASE_LOG2 - {1'b0, tszCode};
    end

endmodule

//--- logic/xlc_translation_control_regs.sv
// low-level and hypervisor translation control registers with walker taps
// assumes one request per cycle from the system-register pipe, inputs synchronous
`timescale 1ns/1ps
module xlc_translation_control_regs
    import xlc_pkg::*;
#(
    parameter bit HAS_EL2         = 1'b1,
    parameter bit HAS_ACCESS_FLAG = 1'b1,
    parameter bit HAS_DIRTY       = 1'b1
)(
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst_n,
    // system-register access
    input  wire logic          reqValid,
    input  wire logic          reqWrite,
    input  wire logic [1:0]    reqOp0,
    input  wire logic [2:0]    reqOp1,
    input  wire logic [3:0]    reqCrn,
    input  wire logic [3:0]    reqCrm,
    input  wire logic [2:0]    reqOp2,
    input  wire logic [1:0]    reqEl,
    input  wire logic [63:0]   reqWdata,
    output logic               rspValid,
    output logic [63:0]        rspRdata,
    output logic               rspTrapEl2,
    output logic               rspUndef,
    output logic               rspMiss,
    // configuration from other control registers
    input  wire logic          hostExtension,
    input  wire logic          trapGeneral,
    input  wire logic          readTrapBit,
    input  wire logic          writeTrapBit,
    input  wire logic          nonsecureState,
    // TLB miss
    input  wire logic          tlbMiss,
    input  xlc_regime_e        missRegime,
    input  wire logic          missVaSel,
    output logic               walkStart,
    output logic               xlatFault,
    output logic               walkBaseHigh,
    // descriptor attribute filter
    input  wire logic          descValid,
    input  xlc_regime_e        descRegime,
    input  wire logic          descHigh,
    input  wire logic [4:0]    descAttr,
    output logic               descOutValid,
    output logic [4:0]         descAttrOut,
    // hypervisor program counter load
    input  wire logic          pcLoad,
    input  wire logic [63:0]   pcTarget,
    output logic               pcOutValid,
    output logic [63:0]        pcOut,
    // walker configuration
    output logic               hypTopByteIgnore,
    output logic               hypAccessFlagEn,
    output logic               hypDirtyEn,
    output xlc_gran_e          lowGranule,
    output xlc_share_e         lowShare,
    output xlc_cache_e         lowOuterCache,
    output xlc_cache_e         lowInnerCache,
    output logic [5:0]         lowPaBits,
    output logic [6:0]         lowRegionLog2,
    output xlc_gran_e          hypGranule,
    output xlc_share_e         hypShare,
    output xlc_cache_e         hypOuterCache,
    output xlc_cache_e         hypInnerCache,
    output logic [5:0]         hypPaBits,
    output logic [6:0]         hypRegionLog2
);

    // absent optional bits drop out of the writable masks
    localparam logic [63:0] HdHi = HAS_DIRTY ? 64'h0 : (64'h1 << HD_HI_POS);
    localparam logic [63:0] HaHi =
        HAS_ACCESS_FLAG ? 64'h0 : (64'h1 << HA_HI_POS);
    localparam logic [63:0] HdLo = HAS_DIRTY ? 64'h0 : (64'h1 << HD_LO_POS);
    localparam logic [63:0] HaLo =
        HAS_ACCESS_FLAG ? 64'h0 : (64'h1 << HA_LO_POS);
    localparam logic [63:0] LowMask  = LOW_WMASK & ~HdHi & ~HaHi;
    localparam logic [63:0] Hyp0Mask = HYP0_WMASK & ~HdLo & ~HaLo;
    localparam logic [63:0] Hyp1Mask = HYP1_WMASK & ~HdHi & ~HaHi;

    // reset release
    logic rstMeta;
    logic rstSync;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // stored registers and their readback views
    logic [63:0] lowReg;
    logic [63:0] hypReg;
    logic [63:0] hypMask;
    logic [63:0] hypRead;
    logic        e2h;

    always_comb begin
        e2h     = hostExtension & HAS_EL2;
        hypMask = e2h ? Hyp1Mask : Hyp0Mask;
        // bits outside the live layout are hidden, not lost
        hypRead = HAS_EL2 ? ((hypReg & hypMask) | (e2h ? 64'h0 : HYP0_RES1))
                          : 64'h0;
    end

    // access decode
    xlc_tgt_e tgt;
    logic     deny;
    logic     trap;
    logic     sysMatch;

    always_comb begin
        tgt      = TGT_NONE;
        deny     = 1'b0;
        trap     = 1'b0;
        sysMatch = reqOp0 == SYS_OP0 && reqCrn == SYS_CRN
                && reqCrm == SYS_CRM && reqOp2 == SYS_OP2;
        if (sysMatch && reqOp1 == OP1_LOW) begin
            if (reqEl == EL0) begin
                deny = 1'b1;
            end else if (reqEl == EL2 && e2h && nonsecureState) begin
                tgt = TGT_HYP;
            end else begin
                tgt = TGT_LOW;
            end
            if (reqEl == EL1 && HAS_EL2 && nonsecureState
                    && (!e2h || !trapGeneral)) begin
                trap = reqWrite ? writeTrapBit : readTrapBit;
            end
        end else if (sysMatch && reqOp1 == OP1_ALIAS) begin
            if ((reqEl == EL2 || reqEl == EL3) && e2h && nonsecureState) begin
                tgt = TGT_LOW;
            end else begin
                deny = 1'b1;
            end
        end else if (sysMatch && reqOp1 == OP1_HYP) begin
            if (reqEl == EL0 || reqEl == EL1) begin
                deny = 1'b1;
            end else begin
                tgt = HAS_EL2 ? TGT_HYP : TGT_ZERO;
            end
        end
    end

    // register file and response
    logic [63:0] next_lowReg;
    logic [63:0] next_hypReg;
    logic        next_rspValid;
    logic [63:0] next_rspRdata;
    logic        next_rspTrapEl2;
    logic        next_rspUndef;
    logic        next_rspMiss;
    logic        doWrite;

    always_comb begin
        next_lowReg     = lowReg;
        next_hypReg     = hypReg;
        next_rspValid   = reqValid;
        next_rspRdata   = 64'h0;
        next_rspTrapEl2 = reqValid & trap;
        next_rspUndef   = reqValid & deny;
        next_rspMiss    = reqValid & ~sysMatch;
        doWrite         = reqValid & reqWrite & ~deny & ~trap;
        // one access per cycle keeps both names in order; software must
        // still synchronise across names at EL3
        if (doWrite && tgt == TGT_LOW) begin
            next_lowReg = reqWdata & LowMask;
        end
        if (doWrite && tgt == TGT_HYP) begin
            next_hypReg = reqWdata & hypMask;
        end
        if (reqValid && !reqWrite && !deny && !trap) begin
            if (tgt == TGT_LOW) begin
                next_rspRdata = lowReg;
            end else if (tgt == TGT_HYP) begin
                next_rspRdata = hypRead;
            end
        end
    end

    // unknown reset value realised as zero
    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            lowReg     <= REG_RESET;
            hypReg     <= REG_RESET;
            rspValid   <= 1'b0;
            rspRdata   <= 64'h0;
            rspTrapEl2 <= 1'b0;
            rspUndef   <= 1'b0;
            rspMiss    <= 1'b0;
        end else begin
            lowReg     <= next_lowReg;
            hypReg     <= next_hypReg;
            rspValid   <= next_rspValid;
            rspRdata   <= next_rspRdata;
            rspTrapEl2 <= next_rspTrapEl2;
            rspUndef   <= next_rspUndef;
            rspMiss    <= next_rspMiss;
        end
    end

    // walker, descriptor and PC paths
    logic        next_walkStart;
    logic        next_xlatFault;
    logic        next_walkBaseHigh;
    logic        next_descOutValid;
    logic [4:0]  next_descAttrOut;
    logic        next_pcOutValid;
    logic [63:0] next_pcOut;
    logic        walkOff;
    logic        hier_perm_disable;
    logic        tbiNow;

    always_comb begin
        walkOff           = 1'b0;
        next_walkBaseHigh = 1'b0;
        if (missRegime == RG_LOW_LEVEL) begin
            walkOff = lowReg[WALK_DISABLE_LOW_POS];
        end else if (e2h) begin
            next_walkBaseHigh = missVaSel;
            walkOff = missVaSel ? hypRead[EPD1_POS] : hypRead[WALK_DISABLE_LOW_POS];
        end
        next_walkStart = tlbMiss & ~walkOff;
        next_xlatFault = tlbMiss & walkOff;
        if (descRegime == RG_LOW_LEVEL) begin
            hier_perm_disable = ~descHigh & lowReg[HIER_PERM_DISABLE_LOW_POS];
        end else if (e2h) begin
            hier_perm_disable = descHigh ? hypRead[HIER_PERM_DISABLE_HIGH_POS] : hypRead[HIER_PERM_DISABLE_LOW_POS];
        end else begin
            hier_perm_disable = ~descHigh & hypRead[HPD_POS];
        end
        // table ns bit survives; permission and never-execute bits drop
        next_descAttrOut  = hier_perm_disable ? (descAttr & ATTR_KEEP_NS) : descAttr;
        next_descOutValid = descValid;
        tbiNow = e2h ? (pcTarget[VA_SEL_POS] ? hypRead[TBI1_POS]
                                             : hypRead[TBI0_POS])
                     : hypRead[TBI_POS];
        next_pcOut = pcTarget;
        if (tbiNow) begin
            next_pcOut[63:56] = (e2h && pcTarget[VA_SEL_POS]) ? TOP_ONE
                                                              : TOP_ZERO;
        end
        next_pcOutValid = pcLoad;
    end

    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            walkStart    <= 1'b0;
            xlatFault    <= 1'b0;
            walkBaseHigh <= 1'b0;
            descOutValid <= 1'b0;
            descAttrOut  <= 5'h00;
            pcOutValid   <= 1'b0;
            pcOut        <= 64'h0;
        end else begin
            walkStart    <= next_walkStart;
            xlatFault    <= next_xlatFault;
            walkBaseHigh <= next_walkBaseHigh;
            descOutValid <= next_descOutValid;
            descAttrOut  <= next_descAttrOut;
            pcOutValid   <= next_pcOutValid;
            pcOut        <= next_pcOut;
        end
    end

    // field decode for both regimes; walker may cache these in TLB entries
    xlc_gran_e  dLowGran;
    xlc_share_e dLowShare;
    xlc_cache_e dLowOuter;
    xlc_cache_e dLowInner;
    logic [5:0] dLowPa;
    logic [6:0] dLowLog2;
    xlc_gran_e  dHypGran;
    xlc_share_e dHypShare;
    xlc_cache_e dHypOuter;
    xlc_cache_e dHypInner;
    logic [5:0] dHypPa;
    logic [6:0] dHypLog2;
    logic [2:0] hypPsCode;

    assign hypPsCode = e2h ? hypRead[IPS_LO +: 3] : hypRead[PS_LO +: 3];

    xlc_field_decode lowDecode (
        .psCode     (lowReg[IPS_LO +: 3]),
        .tgCode     (lowReg[TG_LO +: 2]),
        .shCode     (lowReg[SH_LO +: 2]),
        .orgnCode   (lowReg[ORGN_LO +: 2]),
        .irgnCode   (lowReg[IRGN_LO +: 2]),
        .tszCode    (lowReg[TSZ_LO +: TSZ_W]),
        .granule    (dLowGran),
        .share      (dLowShare),
        .outerCache (dLowOuter),
        .innerCache (dLowInner),
        .paBits     (dLowPa),
        .regionLog2 (dLowLog2)
    );

    xlc_field_decode hypDecode (
        .psCode     (hypPsCode),
        .tgCode     (hypRead[TG_LO +: 2]),
        .shCode     (hypRead[SH_LO +: 2]),
        .orgnCode   (hypRead[ORGN_LO +: 2]),
        .irgnCode   (hypRead[IRGN_LO +: 2]),
        .tszCode    (hypRead[TSZ_LO +: TSZ_W]),
        .granule    (dHypGran),
        .share      (dHypShare),
        .outerCache (dHypOuter),
        .innerCache (dHypInner),
        .paBits     (dHypPa),
        .regionLog2 (dHypLog2)
    );

    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            hypTopByteIgnore <= 1'b0;
            hypAccessFlagEn  <= 1'b0;
            hypDirtyEn       <= 1'b0;
            lowGranule       <= GRAN_4K;
            lowShare         <= SH_NONE;
            lowOuterCache    <= CA_NONCACHE;
            lowInnerCache    <= CA_NONCACHE;
            lowPaBits        <= PA_32;
            lowRegionLog2    <= REGION_BASE_LOG2;
            hypGranule       <= GRAN_4K;
            hypShare         <= SH_NONE;
            hypOuterCache    <= CA_NONCACHE;
            hypInnerCache    <= CA_NONCACHE;
            hypPaBits        <= PA_32;
            hypRegionLog2    <= REGION_BASE_LOG2;
        end else begin
            hypTopByteIgnore <= e2h ? hypRead[TBI0_POS]
                                    : hypRead[TBI_POS];
            hypAccessFlagEn  <= e2h ? hypRead[HA_HI_POS]
                                    : hypRead[HA_LO_POS];
            hypDirtyEn       <= e2h
                ? (hypRead[HD_HI_POS] & hypRead[HA_HI_POS])
                : (hypRead[HD_LO_POS] & hypRead[HA_LO_POS]);
            lowGranule       <= dLowGran;
            lowShare         <= dLowShare;
            lowOuterCache    <= dLowOuter;
            lowInnerCache    <= dLowInner;
            lowPaBits        <= dLowPa;
            lowRegionLog2    <= dLowLog2;
            hypGranule       <= dHypGran;
            hypShare         <= dHypShare;
            hypOuterCache    <= dHypOuter;
            hypInnerCache    <= dHypInner;
            hypPaBits        <= dHypPa;
            hypRegionLog2    <= dHypLog2;
        end
    end

endmodule

//--- testbench/xlc_tcr_monitor.sv
// assertion checker for the translation control bank
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/1ps
module xlc_tcr_monitor
    import xlc_pkg::*;
#(
    parameter bit HAS_EL2 = 1'b1
)(
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // access port
    input wire logic        reqValid,
    input wire logic        reqWrite,
    input wire logic [1:0]  reqOp0,
    input wire logic [2:0]  reqOp1,
    input wire logic [3:0]  reqCrn,
    input wire logic [3:0]  reqCrm,
    input wire logic [2:0]  reqOp2,
    input wire logic [1:0]  reqEl,
    input wire logic        rspValid,
    input wire logic        rspTrapEl2,
    input wire logic        rspUndef,
    // configuration
    input wire logic        hostExtension,
    input wire logic        trapGeneral,
    input wire logic        readTrapBit,
    input wire logic        nonsecureState,
    // walker taps
    input wire logic        tlbMiss,
    input xlc_regime_e      missRegime,
    input wire logic        walkStart,
    input wire logic        xlatFault,
    input wire logic        descValid,
    input wire logic [4:0]  descAttr,
    input wire logic [4:0]  descAttrOut,
    input wire logic        pcLoad,
    input wire logic [63:0] pcTarget,
    input wire logic [63:0] pcOut,
    input wire logic        hypAccessFlagEn,
    input wire logic        hypDirtyEn,
    input wire logic [6:0]  lowRegionLog2
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic ours = reqOp0 == SYS_OP0 && reqCrn == SYS_CRN
        && reqCrm == SYS_CRM && reqOp2 == SYS_OP2
        && reqOp1 inside {OP1_LOW, OP1_HYP, OP1_ALIAS};
    sequence s_trap_read;
        HAS_EL2 && reqValid && !reqWrite && ours && reqOp1 == OP1_LOW
        && reqEl == EL1 && nonsecureState && readTrapBit
        && (!hostExtension || !trapGeneral);
    endsequence
    sequence s_trapped;
        rspValid && rspTrapEl2 && !rspUndef;
    endsequence
    a_resp_follows: assert property (reqValid |=> rspValid)
        else $error("no response after request");
    a_no_stray: assert property (rspValid |-> $past(reqValid))
        else $error("response without request");
    a_el0_denied: assert property (reqValid && ours && reqEl == EL0
        |=> rspUndef) else $error("EL0 access not denied");
    a_read_trap: assert property (s_trap_read |=> s_trapped)
        else $error("EL1 read not trapped");
    a_walk_onehot: assert property (tlbMiss |=> walkStart ^ xlatFault)
        else $error("miss outcome not exactly one");
    a_hyp_walks: assert property (tlbMiss && missRegime == RG_HYP
        && !hostExtension |=> walkStart) else $error("hyp miss faulted");
    a_ns_kept: assert property (descValid |=> descAttrOut[4]
        == $past(descAttr[4]) && (descAttrOut & ~$past(descAttr)) == 5'h00)
        else $error("descriptor filter set bits");
    a_pc_low_kept: assert property (pcLoad
        |=> pcOut[55:0] == $past(pcTarget[55:0]))
        else $error("pc low bits altered");
    a_dirty_gated: assert property (hypDirtyEn |-> hypAccessFlagEn)
        else $error("dirty without access flag");
    a_region_range: assert property (lowRegionLog2 != 7'h00
        && lowRegionLog2 <= 7'h40) else $error("region size out of range");
endmodule

bind xlc_translation_control_regs xlc_tcr_monitor #(.HAS_EL2(HAS_EL2)) u_mon (.*);

//--- testbench/xlc_translation_control_regs_tb.sv
// self-checking bench for the translation control bank
// assumes the monitor is bound in; inputs change at the falling edge
`timescale 1ns/1ps
module xlc_translation_control_regs_tb
    import xlc_pkg::*;
;
    logic clock = 0, rst_n = 0, reqValid = 0, reqWrite = 0;
    logic [1:0] reqOp0 = SYS_OP0, reqEl = 0;
    logic [2:0] reqOp1 = 0, reqOp2 = SYS_OP2;
    logic [3:0] reqCrn = SYS_CRN, reqCrm = SYS_CRM;
    logic [63:0] reqWdata = 0, pcTarget = 0, rspRdata, pcOut;
    logic hostExtension = 0, trapGeneral = 0, readTrapBit = 0;
    logic writeTrapBit = 0, nonsecureState = 1, tlbMiss = 0;
    logic missVaSel = 0, descValid = 0, descHigh = 0, pcLoad = 0;
    xlc_regime_e missRegime = RG_LOW_LEVEL, descRegime = RG_LOW_LEVEL;
    logic [4:0] descAttr = 0, descAttrOut, a;
    logic rspValid, rspTrapEl2, rspUndef, rspMiss, walkStart, xlatFault;
    logic walkBaseHigh, descOutValid, pcOutValid, hypTopByteIgnore;
    logic hypAccessFlagEn, hypDirtyEn, f, hier_perm_disable, hi, t;
    xlc_gran_e lowGranule, hypGranule;
    xlc_share_e lowShare, hypShare;
    xlc_cache_e lowOuterCache, lowInnerCache, hypOuterCache, hypInnerCache;
    logic [5:0] lowPaBits, hypPaBits;
    logic [6:0] lowRegionLog2, hypRegionLog2;
    logic [63:0] rd, w, p, lowM = 0, hypM = 0;
    logic [2:0] fl;
    int n_mismatch = 0, cmp_count = 0;
    int pa[8] = '{32, 36, 40, 42, 44, 48, 48, 48};
    // reserved granule reads as 4KB, reserved shareability as none
    logic [1:0] gr[4] = '{0, 2, 1, 0};
    logic [1:0] sh[4] = '{0, 0, 1, 2};

    xlc_translation_control_regs u_dut (.*);

    always #2 clock = ~clock;

    task automatic chk(input logic [127:0] g, e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic end_sim();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one access; response stands one cycle so it is captured here
    task automatic acc(input logic wr, input logic [2:0] op1,
                       input logic [1:0] el, input logic [63:0] wd);
        reqValid = 1;
        reqWrite = wr;
        reqOp1 = op1;
        reqEl = el;
        reqWdata = wd;
        @(negedge clock);
        chk(rspValid, 1);
        rd = rspRdata;
        fl = {rspTrapEl2, rspUndef, rspMiss};
        reqValid = 0;
        @(negedge clock);
    endtask

    // miss, descriptor and pc load together; all three are independent
    task automatic side(input xlc_regime_e rg, input logic h, ef, eh);
        missRegime = rg;
        descRegime = rg;
        missVaSel = h;
        descHigh = h;
        a = 5'($urandom);
        descAttr = a;
        p = {$urandom, $urandom};
        pcTarget = p;
        tlbMiss = 1;
        descValid = 1;
        pcLoad = 1;
        t = hostExtension ? (p[55] ? hypM[38] : hypM[37]) : hypM[20];
        @(negedge clock);
        chk({walkStart, xlatFault}, {!ef, ef});
        chk({descOutValid, pcOutValid}, 2'h3);
        if (rg == RG_HYP && hostExtension) chk(walkBaseHigh, h);
        chk(descAttrOut, eh ? a & 5'h10 : a);
        chk(pcOut, t ? {hostExtension && p[55] ? 8'hFF : 8'h00,
            p[55:0]} : p);
        tlbMiss = 0;
        descValid = 0;
        pcLoad = 0;
        @(negedge clock);
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        n_mismatch++;
        end_sim();
    end

    initial begin
        void'($urandom(96));
        repeat (20) @(posedge clock);
        @(negedge clock);
        rst_n = 1;
        repeat (3) @(negedge clock);
        for (int i = 0; i < 8; i++) begin
            w = {$urandom, $urandom};
            w[15:8] = {4{i[1:0]}};
            w[34:32] = i[2:0];
            acc(1, OP1_LOW, EL1, w);
            chk(rd, 0);
            lowM = w & LOW_WMASK;
            acc(0, OP1_LOW, EL1, 0);
            chk(rd, lowM);
            chk(lowPaBits, pa[i]);
            chk(lowRegionLog2, 64 - lowM[5:0]);
            chk({lowGranule, lowShare}, {gr[i % 4], sh[i % 4]});
            chk({lowOuterCache, lowInnerCache}, w[11:8]);
            side(RG_LOW_LEVEL, i[0], lowM[7], !i[0] && lowM[41]);
        end
        for (int i = 0; i < 16; i++) begin
            hostExtension = i[0];
            w = {$urandom, $urandom};
            w[18:16] = i[3:1];
            w[34:32] = i[3:1];
            acc(1, OP1_HYP, EL2, w);
            hypM = i[0] ? w & HYP1_WMASK : w & HYP0_WMASK | HYP0_RES1;
            acc(0, OP1_LOW, EL2, 0);
            chk(rd, i[0] ? hypM : lowM);
            acc(0, OP1_ALIAS, EL2, 0);
            chk({fl, rd}, i[0] ? {3'h0, lowM} : {3'h2, 64'h0});
            acc(0, OP1_HYP, EL3, 0);
            chk(rd, hypM);
            chk(hypPaBits, pa[i[3:1]]);
            chk(hypRegionLog2, 64 - hypM[5:0]);
            chk({hypGranule, hypShare, hypOuterCache, hypInnerCache},
                {gr[hypM[15:14]], sh[hypM[13:12]], hypM[11:8]});
            chk({hypAccessFlagEn, hypDirtyEn}, i[0] ? {hypM[39], hypM[40]
                & hypM[39]} : {hypM[21], hypM[22] & hypM[21]});
            if (!i[0]) chk(hypTopByteIgnore, hypM[20]);
            hi = w[63];
            f = i[0] && (hi ? hypM[23] : hypM[7]);
            hier_perm_disable = i[0] ? (hi ? hypM[42] : hypM[41]) : !hi && hypM[24];
            side(RG_HYP, hi, f, hier_perm_disable);
        end
        hostExtension = 0;
        acc(0, OP1_LOW, EL0, 0);
        chk(fl, 3'h2);
        acc(0, OP1_HYP, EL1, 0);
        chk(fl, 3'h2);
        reqCrm = 4'h1;
        acc(0, OP1_LOW, EL1, 0);
        chk(fl, 3'h1);
        reqCrm = SYS_CRM;
        readTrapBit = 1;
        writeTrapBit = 1;
        acc(0, OP1_LOW, EL1, 0);
        chk({fl, rd}, {3'h4, 64'h0});
        acc(1, OP1_LOW, EL1, '1);
        chk(fl, 3'h4);
        hostExtension = 1;
        acc(0, OP1_LOW, EL1, 0);
        chk(fl, 3'h4);
        hostExtension = 0;
        nonsecureState = 0;
        acc(0, OP1_LOW, EL1, 0);
        chk({fl, rd}, {3'h0, lowM});
        end_sim();
    end
endmodule
